// ==== logic/fault_status_pkg.sv ====
package fault_status_pkg;
  localparam int NUM_PAIRS = 8;
  localparam int REG_WIDTH = 24;
  localparam int ADDR_WIDTH = 2;
  localparam logic [1:0] CONFIG_OFFSET = 2'h0;
  localparam logic [1:0] FAULT_STATUS_OFFSET = 2'h1;
  localparam logic [23:0] CONFIG_RESET = 24'h000000;
  localparam logic [23:0] FAULT_STATUS_RESET = 24'h000000;
  localparam int DIAG_SELECT_LSB = 16;
  localparam int SHORT_FLAG_LSB = 8;
  localparam int THERMAL_BIT = 7;
  localparam int CMD_ERR_BIT = 6;
  localparam int CRC_WIDTH = 6;
  localparam logic [6:0] CRC_POLY = 7'h43;
  localparam logic [5:0] CRC_SEED = 6'h00;

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [REG_WIDTH-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [NUM_PAIRS-1:0] open_det;
    logic [NUM_PAIRS-1:0] short_det;
    logic thermal_det;
    logic cmd_err_det;
  } fault_events_t;
endpackage

// ==== logic/config_checksum.sv ====
`timescale 1ns/1ns
module config_checksum
  import fault_status_pkg::*;
(
  input wire logic [REG_WIDTH-1:0] config_word, // Configuration contents
  output logic [CRC_WIDTH-1:0] checksum // Combinational remainder
);
  function automatic logic [CRC_WIDTH-1:0] crc_step(input logic [CRC_WIDTH-1:0] crc, input logic din);
    logic fb;
    fb = crc[CRC_WIDTH-1] ^ din;
    crc_step = {crc[CRC_WIDTH-2:0], 1'b0} ^ (fb ? CRC_POLY[CRC_WIDTH-1:0] : '0);
  endfunction

  logic [CRC_WIDTH-1:0] chain [0:REG_WIDTH];
  assign chain[0] = CRC_SEED;
  // Most significant bit enters first, matching shift order
  for (genvar i = 0; i < REG_WIDTH; i++) begin : g_crc
    assign chain[i+1] = crc_step(chain[i], config_word[REG_WIDTH-1-i]);
  end
  assign checksum = chain[REG_WIDTH];
endmodule

// ==== logic/led_fault_readback_status.sv ====
// The strobed register port was decided locally.
`timescale 1ns/1ns
module led_fault_readback_status
  import fault_status_pkg::*;
(
  input wire logic clock, // 100 MHz clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [ADDR_WIDTH-1:0] addr, // Register address
  input wire logic [REG_WIDTH-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [REG_WIDTH-1:0] rdata, // Read data, cycle after rd
  input wire logic [NUM_PAIRS-1:0] open_det, // LED-open detect per pair
  input wire logic [NUM_PAIRS-1:0] short_det, // LED-short detect per pair
  input wire logic thermal_det, // Thermal shutdown detect
  input wire logic transfer_done, // Serial transfer finished pulse
  input wire logic transfer_cmd_err, // That transfer had a command error
  output logic [NUM_PAIRS-1:0] diag_mode, // Pair pin in diagnostic use
  output logic [2*NUM_PAIRS-1:0] drain_on // Open-drain switch enables
);
  reg_req_t req;
  fault_events_t ev;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign ev = '{open_det: open_det, short_det: short_det, thermal_det: thermal_det,
                cmd_err_det: transfer_cmd_err};

  logic [REG_WIDTH-1:0] config_reg;
  logic [NUM_PAIRS-1:0] open_reg, open_next;
  logic [NUM_PAIRS-1:0] short_reg, short_next;
  logic thermal_reg, thermal_next;
  logic cmd_err_reg, cmd_err_next;
  logic [REG_WIDTH-1:0] rdata_reg, rdata_next;
  logic [CRC_WIDTH-1:0] checksum;
  logic [REG_WIDTH-1:0] status_word;
  logic [2*NUM_PAIRS-1:0] fault_bits;

  // One address-qualified strobe decode, shared by the write and read paths
  function automatic logic strobe_hit(input logic strobe, input logic [ADDR_WIDTH-1:0] a,
      input logic [ADDR_WIDTH-1:0] off);
    strobe_hit = strobe && a == off;
  endfunction

  wire cfg_wr = strobe_hit(req.wr, req.addr, CONFIG_OFFSET);
  wire status_rd = strobe_hit(req.rd, req.addr, FAULT_STATUS_OFFSET);
  wire [NUM_PAIRS-1:0] diag_sel = config_reg[DIAG_SELECT_LSB +: NUM_PAIRS];

  config_checksum u_checksum (
    .config_word(config_reg),
    .checksum(checksum)
  );

  // Set wins over read-clear so an event in the read cycle is kept
  assign open_next = (status_rd ? '0 : open_reg) | (ev.open_det & diag_sel);
  assign short_next = (status_rd ? '0 : short_reg) | (ev.short_det & diag_sel);
  assign thermal_next = (status_rd ? 1'b0 : thermal_reg) | ev.thermal_det;
  // Each finished transfer overwrites the flag with its own verdict
  assign cmd_err_next = transfer_done ? ev.cmd_err_det : (status_rd ? 1'b0 : cmd_err_reg);

  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pack
    assign fault_bits[2*p+1] = open_reg[p];
    assign fault_bits[2*p] = short_reg[p];
  end
  assign status_word = {fault_bits, thermal_reg, cmd_err_reg, checksum};

  // Config is write-only, so it reads back as zero
  assign rdata_next = status_rd ? status_word : '0;

  // Shared pin drives only when left as plain output
  for (genvar c = 0; c < 2*NUM_PAIRS; c++) begin : g_drain
    if (c % 2 == 1) begin : g_shared
      assign drain_on[c] = config_reg[c] & ~diag_sel[c/2];
    end else begin : g_plain
      assign drain_on[c] = config_reg[c];
    end
  end
  assign diag_mode = diag_sel;
  assign rdata = rdata_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      config_reg <= CONFIG_RESET;
      {open_reg, short_reg, thermal_reg, cmd_err_reg} <= FAULT_STATUS_RESET[REG_WIDTH-1:CRC_WIDTH];
      rdata_reg <= '0;
    end else begin
      if (cfg_wr) config_reg <= req.wdata;
      open_reg <= open_next;
      short_reg <= short_next;
      thermal_reg <= thermal_next;
      cmd_err_reg <= cmd_err_next;
      rdata_reg <= rdata_next;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_status_read;
    strobe_hit(rd, addr, FAULT_STATUS_OFFSET);
  endsequence

  sequence s_config_write;
    strobe_hit(wr, addr, CONFIG_OFFSET);
  endsequence

  sequence s_other_read;
    rd && addr != FAULT_STATUS_OFFSET;
  endsequence

  // Cycle with no detector active and no transfer ending
  sequence s_no_event;
    open_det == '0 && short_det == '0 && !thermal_det && !transfer_done;
  endsequence

  a_open_set_gated: assert property ((open_det[0] && diag_sel[0]) |=> open_reg[0])
    else $error("open flag not latched");
  a_open_masked: assert property ((open_reg & ~$past(open_reg) & ~$past(diag_sel)) == '0)
    else $error("open flag on non-diag pair");
  a_short_hold: assert property ((short_reg[7] && !status_rd) |=> short_reg[7])
    else $error("short flag lost without read");
  a_read_clears: assert property ((s_status_read and !thermal_det) |=> !thermal_reg)
    else $error("thermal flag not cleared by read");
  a_read_data: assert property (s_status_read |=> rdata == {$past(fault_bits), $past(thermal_reg), $past(cmd_err_reg), $past(checksum)})
    else $error("read data mismatch");
  a_cmd_err_latest: assert property (transfer_done |=> cmd_err_reg == $past(transfer_cmd_err))
    else $error("command error not from last transfer");
  a_cmd_err_clear: assert property ((s_status_read and !transfer_done) |=> !cmd_err_reg)
    else $error("command error not cleared");
  a_crc_stable: assert property ($stable(config_reg) |-> $stable(checksum))
    else $error("checksum moved without config change");
  a_drain_gated: assert property (diag_sel[7] |-> !drain_on[15])
    else $error("diag pin still driven");

  // Read data stand only in the cycle after a status read
  a_rdata_idle: assert property (!strobe_hit(rd, addr, FAULT_STATUS_OFFSET)
    |=> rdata == '0)
    else $error("read data outside a status read");
  a_other_read: assert property (s_other_read
    |=> rdata == '0)
    else $error("other address read not zero");
  a_flags_quiet: assert property ((s_status_read ##0 s_no_event)
    |=> {open_reg, short_reg, thermal_reg, cmd_err_reg} == '0)
    else $error("read did not clear flags");
  a_thermal_set: assert property (thermal_det
    |=> thermal_reg)
    else $error("thermal flag not latched");
  a_thermal_keep: assert property ((thermal_reg && !status_rd)
    |=> thermal_reg)
    else $error("thermal flag lost without read");
  a_thermal_quiet: assert property ((!thermal_reg && !thermal_det)
    |=> !thermal_reg)
    else $error("thermal flag set without event");
  a_set_beats_read: assert property ((s_status_read ##0 thermal_det)
    |=> thermal_reg)
    else $error("event lost in read cycle");
  // Command error follows transfers; reads only clear it
  a_cmd_err_keep: assert property ((!transfer_done && !status_rd)
    |=> $stable(cmd_err_reg))
    else $error("command error moved without transfer");
  a_cmd_err_quiet: assert property ((!transfer_done && !cmd_err_reg)
    |=> !cmd_err_reg)
    else $error("command error set without transfer");
  a_transfer_wins: assert property ((s_status_read ##0 transfer_done)
    |=> cmd_err_reg == $past(transfer_cmd_err))
    else $error("transfer verdict lost in read cycle");
  // Checksum moves only with a configuration write
  a_crc_on_read: assert property (s_status_read
    |=> $stable(checksum))
    else $error("checksum moved by read");
  a_status_write: assert property (strobe_hit(wr, addr, FAULT_STATUS_OFFSET)
    |=> $stable(checksum) && $stable(diag_mode))
    else $error("status write changed state");
  a_config_hold: assert property (!strobe_hit(wr, addr, CONFIG_OFFSET)
    |=> $stable(diag_mode) && $stable(drain_on))
    else $error("pin setup moved without write");
  a_config_lands: assert property (s_config_write
    |=> diag_mode == $past(wdata[DIAG_SELECT_LSB +: NUM_PAIRS]))
    else $error("diag select not written");

  // Per-pair flag and pin behaviour
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair_checks
    a_open_latch: assert property ((open_det[p] && diag_sel[p])
      |=> open_reg[p])
      else $error("open flag not latched");
    a_short_latch: assert property ((short_det[p] && diag_sel[p])
      |=> short_reg[p])
      else $error("short flag not latched");
    a_open_keep: assert property ((open_reg[p] && !status_rd)
      |=> open_reg[p])
      else $error("open flag lost without read");
    a_short_keep: assert property ((short_reg[p] && !status_rd)
      |=> short_reg[p])
      else $error("short flag lost without read");
    a_open_idle: assert property ((!diag_sel[p] && !open_reg[p])
      |=> !open_reg[p])
      else $error("open flag on plain pair");
    a_short_idle: assert property ((!diag_sel[p] && !short_reg[p])
      |=> !short_reg[p])
      else $error("short flag on plain pair");
    a_open_readout: assert property (s_status_read
      |=> rdata[SHORT_FLAG_LSB+2*p+1] == $past(open_reg[p]))
      else $error("open flag read at wrong bit");
    a_short_readout: assert property (s_status_read
      |=> rdata[SHORT_FLAG_LSB+2*p] == $past(short_reg[p]))
      else $error("short flag read at wrong bit");
    a_pin_diag: assert property ((s_config_write ##0 wdata[DIAG_SELECT_LSB+p])
      |=> !drain_on[2*p+1])
      else $error("diag pin still switched");
    a_pin_shared: assert property ((s_config_write ##0 !wdata[DIAG_SELECT_LSB+p])
      |=> drain_on[2*p+1] == $past(wdata[2*p+1]))
      else $error("shared pin not following config");
    a_pin_plain: assert property (s_config_write
      |=> drain_on[2*p] == $past(wdata[2*p]))
      else $error("plain pin not following config");
  end
endmodule

// ==== sim/fault_source.sv ====
`timescale 1ns/1ns
module fault_source
  import fault_status_pkg::*;
(
  input wire logic clock, // Bench clock
  input wire logic go, // Show ev for one cycle
  input wire logic xfer, // End a serial transfer
  input wire fault_events_t ev, // Event pattern
  output logic [NUM_PAIRS-1:0] open_det, // Open levels
  output logic [NUM_PAIRS-1:0] short_det, // Short levels
  output logic thermal_det, // Thermal level
  output logic transfer_done, // Transfer end pulse
  output logic transfer_cmd_err // Error with that pulse
);
  always @(posedge clock) begin
    open_det <= go ? ev.open_det : '0;
    short_det <= go ? ev.short_det : '0;
    thermal_det <= go & ev.thermal_det;
    transfer_done <= xfer;
    // Meaningless outside the pulse, so it shows the opposite there
    transfer_cmd_err <= xfer ? ev.cmd_err_det : ~ev.cmd_err_det;
  end
endmodule

// ==== sim/led_fault_readback_status_tb.sv ====
`timescale 1ns/1ns
module led_fault_readback_status_tb;
  import fault_status_pkg::*;
  logic clock = '0, rst_b = '0, wr = '0, rd = '0, go = '0, xfer = '0;
  logic [1:0] addr = '0;
  logic [23:0] wdata = '0, rdata;
  logic [7:0] open_det, short_det, diag_mode;
  logic [15:0] drain_on;
  logic thermal_det, transfer_done, transfer_cmd_err;
  fault_events_t ev = '0;
  int error_cnt = 0, comparisons = 0;
  always #5 clock = ~clock;
  fault_source src(.clock(clock), .go(go), .xfer(xfer), .ev(ev), .open_det(open_det), .short_det(short_det),
    .thermal_det(thermal_det), .transfer_done(transfer_done), .transfer_cmd_err(transfer_cmd_err));
  led_fault_readback_status DUT(.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .open_det(open_det), .short_det(short_det), .thermal_det(thermal_det),
    .transfer_done(transfer_done), .transfer_cmd_err(transfer_cmd_err), .diag_mode(diag_mode), .drain_on(drain_on));
  task check(logic [23:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [5:0] crc6(logic [23:0] d);
    crc6 = CRC_SEED;
    for (int i = 23; i >= 0; i--) crc6 = {crc6[4:0], 1'h0} ^ ((crc6[5] ^ d[i]) ? CRC_POLY[5:0] : 6'h00);
  endfunction
  function automatic logic [23:0] st(logic [7:0] o, s, logic t, c, logic [5:0] k);
    st = {16'h0000, t, c, k};
    for (int i = 0; i < 8; i++) {st[9+2*i], st[8+2*i]} = {o[i], s[i]};
  endfunction
  task wr_reg(logic [1:0] a, logic [23:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
  endtask
  task rd_reg(logic [1:0] a, logic [23:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'h1;
    @(posedge clock);
    rd <= 1'h0;
    #1 check(rdata, exp);
  endtask
  task inject(fault_events_t e, logic x);
    @(posedge clock);
    ev <= e;
    go <= 1'h1;
    xfer <= x;
    @(posedge clock);
    go <= 1'h0;
    xfer <= 1'h0;
    repeat (2) @(posedge clock);
  endtask
  task t_reset;
    rd_reg(2'h1, 24'h000000);
    check({diag_mode, drain_on}, 24'h000000);
    $display("reset test done");
  endtask
  task t_faults;
    wr_reg(2'h0, 24'hffffff);
    #1 check({diag_mode, drain_on}, 24'hff5555);
    inject({8'ha5, 8'h3c, 2'h3}, 1'h1);
    rd_reg(2'h1, st(8'ha5, 8'h3c, 1'h1, 1'h1, crc6(24'hffffff)));
    wr_reg(2'h1, 24'hffffff);
    rd_reg(2'h1, {18'h0, crc6(24'hffffff)});
    inject(18'h00001, 1'h1);
    inject('0, 1'h1);
    rd_reg(2'h1, {18'h0, crc6(24'hffffff)});
    $display("fault test done");
  endtask
  task t_partial;
    wr_reg(2'h0, 24'h0f1234);
    #1 check({diag_mode, drain_on}, 24'h0f1214);
    inject({16'hffff, 2'h0}, 1'h0);
    rd_reg(2'h1, st(8'h0f, 8'h0f, 1'h0, 1'h0, crc6(24'h0f1234)));
    rd_reg(2'h0, 24'h000000);
    $display("partial diag test done");
  endtask
  task t_race;
    // Events reach the block at the same edge as the read strobe
    fork
      inject({8'h01, 8'h00, 1'h1, 1'h1}, 1'h1);
      begin
        @(posedge clock);
        rd_reg(2'h1, {18'h0, crc6(24'h0f1234)});
      end
    join
    rd_reg(2'h1, st(8'h01, 8'h00, 1'h1, 1'h1, crc6(24'h0f1234)));
    $display("event during read test done");
  endtask
  task t_midreset;
    inject({8'h00, 8'h01, 1'h1, 1'h0}, 1'h0);
    @(posedge clock);
    rst_b <= 1'h0;
    repeat (2) @(posedge clock);
    #1 check({diag_mode, drain_on}, 24'h000000);
    @(posedge clock);
    rst_b <= 1'h1;
    rd_reg(2'h1, {18'h0, crc6(24'h000000)});
    $display("mid-run reset test done");
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'h1;
    t_reset;
    t_faults;
    t_partial;
    t_race;
    t_midreset;
    summarize;
  end
  initial begin
    #100000;
    error_cnt++;
    summarize;
  end
endmodule
